/* File: rtl/tlm_pkg.sv */
// Purpose: shared constants and types for the limit status and diode config bank
// Assumes: one byte-wide register port from the serial protocol engine
// Notes:   offsets are byte register addresses on the serial bus
package tlm_pkg;

  // register addresses
  localparam logic [7:0] ADDR_ALERT_MASK = 8'h1F;  // per-channel alert suppress
  localparam logic [7:0] ADDR_CONSEC     = 8'h22;  // consecutive measurement counts
  localparam logic [7:0] ADDR_BETA1      = 8'h25;  // ext1_beta_config
  localparam logic [7:0] ADDR_BETA2      = 8'h26;  // ext2_beta_config
  localparam logic [7:0] ADDR_IDEAL1     = 8'h27;  // ext1_ideality_factor
  localparam logic [7:0] ADDR_IDEAL2     = 8'h28;  // ext2_ideality_factor
  localparam logic [7:0] ADDR_IDEAL3     = 8'h31;  // ext3_ideality_factor
  localparam logic [7:0] ADDR_IDEAL4     = 8'h39;  // ext4_ideality_factor
  localparam logic [7:0] ADDR_HIGH       = 8'h3A;  // high_limit_flags
  localparam logic [7:0] ADDR_LOW        = 8'h3B;  // low_limit_flags
  localparam logic [7:0] ADDR_THERM      = 8'h3C;  // overtemp_limit_flags

  // channel counts and field layout
  localparam int          NUM_CH        = 5;      // internal plus four external
  localparam int          NUM_BETA      = 2;      // beta logic on ext1 and ext2
  localparam int          NUM_IDEAL     = 4;      // ideality on ext1..ext4
  localparam int          BETA_EN_BIT   = 4;      // auto_beta_on position
  localparam int          BETA_W        = 4;      // beta field width
  localparam int          IDEAL_W       = 6;      // diode_factor_value width
  localparam int          CTHRM_LSB     = 4;      // overtemp_consecutive_count lsb
  localparam int          CTHRM_W       = 3;      // overtemp_consecutive_count width
  localparam int          CNT_W         = 3;      // consecutive counter width
  localparam logic [2:0]  CNT_MAX       = 3'h4;   // longest run that matters

  // reset values
  localparam logic [5:0]  IDEAL_RST     = 6'h12;  // binary 010010
  localparam logic [7:0]  CONSEC_RST    = 8'h70;  // count code 111, rest clear
  localparam logic [4:0]  MASK_RST      = 5'h00;  // nothing suppressed
  localparam logic [3:0]  BETA_RST      = 4'h0;   // beta setting after reset

  // register port request from the protocol engine
  typedef struct packed {
    logic [7:0] addr;   // register address
    logic       wr;     // one-cycle write strobe
    logic       rd;     // one-cycle read strobe
    logic [7:0] wdata;  // write data
  } tlm_reg_req_t;

  // comparison results of one finished measurement
  typedef struct packed {
    logic over_high;   // above high limit
    logic under_low;   // below low limit
    logic over_therm;  // above over-temperature limit
    logic under_hyst;  // below over-temperature limit minus hysteresis
  } tlm_meas_t;

  // count code to number of consecutive measurements, 1..4
  function automatic logic [2:0] tlm_consec_target(input logic [2:0] code);
    logic [2:0] n;
    n = 3'h1;
    case (code)
      3'h0:    n = 3'h1;
      3'h1:    n = 3'h2;
      3'h3:    n = 3'h3;
      3'h7:    n = 3'h4;
      default: n = 3'h1;  // undefined codes act as a single measurement
    endcase
    return n;
  endfunction : tlm_consec_target

endpackage : tlm_pkg

/* File: rtl/tlm_beta_chan.sv */
// Purpose: auto-beta enable and beta setting of one external diode
// Assumes: auto detector delivers its result with a one-cycle strobe
// Notes:   write data bit 4 decides whether the same write may set beta
`timescale 1ns/100ps
module tlm_beta_chan
  import tlm_pkg::*;
(
  input  wire logic              clk_sys,
  input  wire logic              reset,
  input  wire logic              wr_en,        // host write to this register
  input  wire logic [7:0]        wdata,        // host write data
  input  wire logic              auto_strobe,  // detector has a new setting
  input  wire logic [BETA_W-1:0] auto_value,   // detector's chosen setting
  output logic                   auto_beta_on_r, // auto detection enabled
  output logic [BETA_W-1:0]      beta_r        // setting in effect
);

  // enable bit, written by the host only
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      auto_beta_on_r <= 1'b0;
    end else if (wr_en) begin
      auto_beta_on_r <= wdata[BETA_EN_BIT];
    end
  end

  // beta field: detector owns it while enabled, host otherwise
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      beta_r <= BETA_RST;
    end else if (auto_beta_on_r && auto_strobe) begin
      beta_r <= auto_value;
    end else if (wr_en && !wdata[BETA_EN_BIT] && !auto_beta_on_r) begin
      beta_r <= wdata[BETA_W-1:0];  // host write lands only when auto is off
    end
  end

endmodule : tlm_beta_chan

/* File: rtl/tlm_chan_status.sv */
// Purpose: high, low and over-temperature flags of one temperature channel
// Assumes: strobe is already qualified for this channel
// Notes:   hardware set wins over a read clear in the same cycle
`timescale 1ns/100ps
module tlm_chan_status
  import tlm_pkg::*;
(
  input  wire logic             clk_sys,
  input  wire logic             reset,
  input  wire logic             present,    // channel exists on this variant
  input  wire logic             strobe,     // measurement finished
  input  wire tlm_meas_t        meas,       // its comparison results
  input  wire logic [CNT_W-1:0] target,     // consecutive count needed
  input  wire logic             clr_high,   // high flags register read
  input  wire logic             clr_low,    // low flags register read
  output logic                  high_r,     // over upper limit flag
  output logic                  low_r,      // under lower limit flag
  output logic                  therm_r     // over-temperature flag
);

  logic [CNT_W-1:0] run_r;    // consecutive over-limit measurements
  logic [CNT_W-1:0] run_inc;  // saturating increment

  assign run_inc = (run_r == CNT_MAX) ? CNT_MAX : run_r + 3'h1;

  // run counter restarts on any measurement that is not over the limit
  always_ff @(posedge clk_sys) begin
    if (reset || !present) begin
      run_r <= '0;
    end else if (strobe) begin
      run_r <= meas.over_therm ? run_inc : '0;
    end
  end

  // high flag: sticky until read
  always_ff @(posedge clk_sys) begin
    if (reset || !present) begin
      high_r <= 1'b0;
    end else if (strobe && meas.over_high) begin
      high_r <= 1'b1;
    end else if (clr_high) begin
      high_r <= 1'b0;
    end
  end

  // low flag: sticky until read
  always_ff @(posedge clk_sys) begin
    if (reset || !present) begin
      low_r <= 1'b0;
    end else if (strobe && meas.under_low) begin
      low_r <= 1'b1;
    end else if (clr_low) begin
      low_r <= 1'b0;
    end
  end

  // over-temperature flag: set after enough runs, cleared by hysteresis
  always_ff @(posedge clk_sys) begin
    if (reset || !present) begin
      therm_r <= 1'b0;
    end else if (strobe && meas.over_therm && run_inc >= target) begin
      therm_r <= 1'b1;
    end else if (strobe && meas.under_hyst) begin
      therm_r <= 1'b0;
    end
  end

endmodule : tlm_chan_status

/* File: rtl/tlm_limit_bank.sv */
// Purpose: limit status flags, diode beta and ideality configuration registers
// Assumes: protocol engine and measurement logic run on clk_sys
// Notes:   read data appears one cycle after the read strobe
//
// Operation
// - bit 4 enables automatic beta detection
// - beta field reads setting in effect
// - auto mode updates beta, ignores host writes
// - six-bit ideality fields reset to 010010
// - over high limit sets channel high flag
// - reading high flags clears them and summary
// - under low limit sets channel low flag
// - reading low flags clears them and summary
// - over-temperature flag asserts over-temperature output
// - over-temperature flags read-only, not read-cleared
// - flag clears below limit minus hysteresis
// - summary over-temperature set when any flag set
// - summary clears only when all flags clear
// - mask gates alert only, never over-temperature
// - over-temperature needs programmed consecutive measurements
`timescale 1ns/100ps
module tlm_limit_bank
  import tlm_pkg::*;
#(
  parameter int NUM_EXT = 4  // external channels fitted on this variant
)
(
  input  wire logic                            clk_sys,
  input  wire logic                            reset,
  input  wire tlm_reg_req_t                    reg_req,
  output logic [7:0]                           reg_rdata_r,
  input  wire logic                            meas_strobe,
  input  wire logic [2:0]                      meas_chan,
  input  wire tlm_meas_t                       meas,
  input  wire logic [NUM_CH-1:1]               diode_fault,
  input  wire logic [NUM_BETA-1:0]             beta_auto_strobe,
  input  wire logic [NUM_BETA-1:0][BETA_W-1:0] beta_auto_value,
  output logic [NUM_BETA-1:0]                  auto_beta_on,
  output logic [NUM_BETA-1:0][BETA_W-1:0]      beta_setting,
  output logic [NUM_IDEAL-1:0][IDEAL_W-1:0]    diode_factor_value,
  output logic                                 status_high_r,
  output logic                                 status_low_r,
  output logic                                 status_therm_r,
  output logic                                 overtemp_assert_r,
  output logic                                 alert_assert_r
);

  // ideality register addresses, index 0 is ext1
  localparam logic [NUM_IDEAL-1:0][7:0] IDEAL_ADDR =
    {ADDR_IDEAL4, ADDR_IDEAL3, ADDR_IDEAL2, ADDR_IDEAL1};

  // beta register addresses, index 0 is ext1
  localparam logic [NUM_BETA-1:0][7:0] BETA_ADDR = {ADDR_BETA2, ADDR_BETA1};

  // register address compare used by every write decode and the flag-clearing read strobes
  function automatic logic reg_hit(input logic [7:0] addr, input logic [7:0] ref_addr);
    return addr == ref_addr;
  endfunction : reg_hit

  // ------------------------------------------------------------------
  // declarations
  // ------------------------------------------------------------------
  logic [NUM_CH-1:0]     present;          // channel fitted on this variant
  logic [NUM_CH-1:0]     chan_strobe;      // measurement strobe per channel
  logic [NUM_CH-1:0]     high_flags;       // high flags, bit 0 internal
  logic [NUM_CH-1:0]     low_flags;        // low flags, bit 0 internal
  logic [NUM_CH-1:0]     therm_flags;      // over-temperature flags
  logic [NUM_CH-1:0]     high_set;         // high flag set events this cycle
  logic [NUM_CH-1:0]     low_set;          // low flag set events this cycle
  logic [NUM_CH-1:0]     alert_suppress_r; // alert mask, bit 0 internal
  logic [7:0]            consec_r;         // consecutive count register
  logic [CNT_W-1:0]      therm_target;     // decoded count for over-temperature
  logic                  rd_high;          // read of the high flags register
  logic                  rd_low;           // read of the low flags register
  logic [7:0]            rdata_nxt;        // read data before the output flop
  logic [NUM_CH-1:0]     alert_cause;      // unmasked out-of-limit or fault

  // ------------------------------------------------------------------
  // variant and channel decode
  // ------------------------------------------------------------------

  // internal channel always fitted, externals up to NUM_EXT
  generate
    for (genvar c = 0; c < NUM_CH; c++) begin : g_present
      assign present[c] = (c <= NUM_EXT);
    end
  endgenerate

  // route the shared measurement strobe to the channel it belongs to
  generate
    for (genvar c = 0; c < NUM_CH; c++) begin : g_strobe
      assign chan_strobe[c] = meas_strobe && (meas_chan == 3'(c)) && present[c];
    end
  endgenerate

  // read strobes that clear flags
  assign rd_high = reg_req.rd && reg_hit(reg_req.addr, ADDR_HIGH);
  assign rd_low  = reg_req.rd && reg_hit(reg_req.addr, ADDR_LOW);

  // the over-temperature flags have no read side effect

  // decode the programmed consecutive count
  assign therm_target = tlm_consec_target(consec_r[CTHRM_LSB +: CTHRM_W]);

  // ------------------------------------------------------------------
  // per-channel status
  // ------------------------------------------------------------------

  // one flag set per channel, absent channels held clear inside
  generate
    for (genvar c = 0; c < NUM_CH; c++) begin : g_chan
      tlm_chan_status u_status (
        .clk_sys  (clk_sys),
        .reset    (reset),
        .present  (present[c]),
        .strobe   (chan_strobe[c]),
        .meas     (meas),
        .target   (therm_target),
        .clr_high (rd_high),
        .clr_low  (rd_low),
        .high_r   (high_flags[c]),
        .low_r    (low_flags[c]),
        .therm_r  (therm_flags[c])
      );
      assign high_set[c] = chan_strobe[c] && meas.over_high;
      assign low_set[c]  = chan_strobe[c] && meas.under_low;
    end
  endgenerate

  // ------------------------------------------------------------------
  // beta configuration on ext1 and ext2
  // ------------------------------------------------------------------

  // each beta register has its own enable and setting
  generate
    for (genvar b = 0; b < NUM_BETA; b++) begin : g_beta
      tlm_beta_chan u_beta (
        .clk_sys        (clk_sys),
        .reset          (reset),
        .wr_en          (reg_req.wr && reg_hit(reg_req.addr, BETA_ADDR[b])),
        .wdata          (reg_req.wdata),
        .auto_strobe    (beta_auto_strobe[b]),
        .auto_value     (beta_auto_value[b]),
        .auto_beta_on_r (auto_beta_on[b]),
        .beta_r         (beta_setting[b])
      );
    end
  endgenerate

  // ------------------------------------------------------------------
  // ideality factor registers
  // ------------------------------------------------------------------

  // writable six-bit factor, absent channels keep their reset value
  generate
    for (genvar i = 0; i < NUM_IDEAL; i++) begin : g_ideal
      always_ff @(posedge clk_sys) begin
        if (reset) begin
          diode_factor_value[i] <= IDEAL_RST;
        end else if (reg_req.wr && reg_hit(reg_req.addr, IDEAL_ADDR[i])
                     && present[i+1]) begin
          diode_factor_value[i] <= reg_req.wdata[IDEAL_W-1:0];
        end
      end
    end
  endgenerate

  // ------------------------------------------------------------------
  // mask and consecutive count registers
  // ------------------------------------------------------------------

  // alert suppress bits, only fitted channels can be set
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      alert_suppress_r <= MASK_RST;
    end else if (reg_req.wr && reg_hit(reg_req.addr, ADDR_ALERT_MASK)) begin
      alert_suppress_r <= reg_req.wdata[NUM_CH-1:0] & present;
    end
  end

  // consecutive count register, bit 0 unused and held low
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      consec_r <= CONSEC_RST;
    end else if (reg_req.wr && reg_hit(reg_req.addr, ADDR_CONSEC)) begin
      consec_r <= {reg_req.wdata[7:1], 1'b0};
    end
  end

  // ------------------------------------------------------------------
  // summary bits of the main status register
  // ------------------------------------------------------------------

  // summary high: a new event beats a read clear in the same cycle
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      status_high_r <= 1'b0;
    end else if (|high_set) begin
      status_high_r <= 1'b1;
    end else if (rd_high) begin
      status_high_r <= 1'b0;
    end
  end

  // summary low: same treatment as summary high
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      status_low_r <= 1'b0;
    end else if (|low_set) begin
      status_low_r <= 1'b1;
    end else if (rd_low) begin
      status_low_r <= 1'b0;
    end
  end

  // summary over-temperature follows the or of all channel flags
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      status_therm_r <= 1'b0;
    end else begin
      status_therm_r <= |therm_flags;
    end
  end

  // ------------------------------------------------------------------
  // output pins
  // ------------------------------------------------------------------

  // over-temperature output ignores the alert mask
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      overtemp_assert_r <= 1'b0;
    end else begin
      overtemp_assert_r <= |(therm_flags & present);
    end
  end

  // alert causes: high and low flags plus diode faults on external channels
  assign alert_cause = (high_flags | low_flags | {diode_fault, 1'b0})
                       & ~alert_suppress_r & present;

  // alert output from masked causes
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      alert_assert_r <= 1'b0;
    end else begin
      alert_assert_r <= |alert_cause;
    end
  end

  // ------------------------------------------------------------------
  // register read
  // ------------------------------------------------------------------

  // read mux, unmapped addresses and reserved bits read zero
  always_comb begin
    rdata_nxt = 8'h00;
    case (reg_req.addr)
      ADDR_ALERT_MASK: rdata_nxt = {3'h0, alert_suppress_r};
      ADDR_CONSEC:     rdata_nxt = consec_r;
      ADDR_BETA1:      rdata_nxt = {3'h0, auto_beta_on[0], beta_setting[0]};
      ADDR_BETA2:      rdata_nxt = {3'h0, auto_beta_on[1], beta_setting[1]};
      ADDR_IDEAL1:     rdata_nxt = {2'h0, diode_factor_value[0]};
      ADDR_IDEAL2:     rdata_nxt = {2'h0, diode_factor_value[1]};
      ADDR_IDEAL3:     rdata_nxt = {2'h0, diode_factor_value[2]};
      ADDR_IDEAL4:     rdata_nxt = {2'h0, diode_factor_value[3]};
      ADDR_HIGH:       rdata_nxt = {3'h0, high_flags};
      ADDR_LOW:        rdata_nxt = {3'h0, low_flags};
      ADDR_THERM:      rdata_nxt = {3'h0, therm_flags};
      default:         rdata_nxt = 8'h00;
    endcase
  end

  // read data captured on the read strobe and held until the next read
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      reg_rdata_r <= 8'h00;
    end else if (reg_req.rd) begin
      reg_rdata_r <= rdata_nxt;
    end
  end

endmodule : tlm_limit_bank

/* File: sim/tlm_limit_monitor.sv */
// Purpose: concurrent checks on the limit bank ports
// Assumes: every channel fitted, all requests on clk_sys
// Notes:   bound into every tlm_limit_bank instance
`timescale 1ns/100ps
module tlm_limit_monitor
  import tlm_pkg::*;
(
  input wire logic                            clk_sys,
  input wire logic                            reset,
  input wire tlm_reg_req_t                    reg_req,
  input wire logic [7:0]                      reg_rdata_r,
  input wire logic                            meas_strobe,
  input wire logic [2:0]                      meas_chan,
  input wire tlm_meas_t                       meas,
  input wire logic [NUM_BETA-1:0]             beta_auto_strobe,
  input wire logic [NUM_BETA-1:0][BETA_W-1:0] beta_auto_value,
  input wire logic [NUM_BETA-1:0]             auto_beta_on,
  input wire logic [NUM_BETA-1:0][BETA_W-1:0] beta_setting,
  input wire logic [NUM_IDEAL-1:0][IDEAL_W-1:0] diode_factor_value,
  input wire logic                            status_high_r,
  input wire logic                            status_low_r,
  input wire logic                            status_therm_r,
  input wire logic                            overtemp_assert_r
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);
  // host read or write of one address
  sequence s_rd(logic [7:0] a); reg_req.rd && reg_req.addr == a; endsequence
  sequence s_wr(logic [7:0] a); reg_req.wr && reg_req.addr == a; endsequence
  // valid channel finishing a measurement
  sequence s_meas; meas_strobe && meas_chan <= 3'h4; endsequence
  property p_beta_en; s_wr(ADDR_BETA1) |=> auto_beta_on[0] == $past(reg_req.wdata[4]); endproperty
  a_beta_en: assert property (p_beta_en) else $error("auto enable not written");
  property p_beta_rd; s_rd(ADDR_BETA1) |=> reg_rdata_r[4:0] == $past({auto_beta_on[0], beta_setting[0]}); endproperty
  a_beta_rd: assert property (p_beta_rd) else $error("beta readback wrong");
  property p_beta_auto; auto_beta_on[0] && beta_auto_strobe[0] |=> beta_setting[0] == $past(beta_auto_value[0]); endproperty
  a_beta_auto: assert property (p_beta_auto) else $error("auto beta not loaded");
  property p_beta_lock; s_wr(ADDR_BETA1) ##0 auto_beta_on[0] && !beta_auto_strobe[0] |=> $stable(beta_setting[0]); endproperty
  a_beta_lock: assert property (p_beta_lock) else $error("beta written in auto mode");
  property p_ideal_rst; $fell(reset) |-> diode_factor_value == {NUM_IDEAL{IDEAL_RST}}; endproperty
  a_ideal_rst: assert property (p_ideal_rst) else $error("ideality reset value wrong");
  property p_ideal_wr; s_wr(ADDR_IDEAL3) |=> diode_factor_value[2] == $past(reg_req.wdata[5:0]); endproperty
  a_ideal_wr: assert property (p_ideal_wr) else $error("ideality not written");
  property p_high_set; s_meas ##0 meas.over_high |=> status_high_r; endproperty
  a_high_set: assert property (p_high_set) else $error("high summary not set");
  property p_high_clr; s_rd(ADDR_HIGH) ##0 !meas_strobe |=> !status_high_r; endproperty
  a_high_clr: assert property (p_high_clr) else $error("high summary not cleared");
  property p_low_set; s_meas ##0 meas.under_low |=> status_low_r; endproperty
  a_low_set: assert property (p_low_set) else $error("low summary not set");
  property p_low_clr; s_rd(ADDR_LOW) ##0 !meas_strobe |=> !status_low_r; endproperty
  a_low_clr: assert property (p_low_clr) else $error("low summary not cleared");
  property p_pin; overtemp_assert_r == status_therm_r; endproperty
  a_pin: assert property (p_pin) else $error("pin and summary disagree");
  property p_therm_ro;
    s_rd(ADDR_THERM) ##0 status_therm_r && !meas_strobe && !$past(meas_strobe) |=> status_therm_r;
  endproperty
  a_therm_ro: assert property (p_therm_ro) else $error("read cleared overtemp");
endmodule : tlm_limit_monitor

bind tlm_limit_bank tlm_limit_monitor u_mon (
  .clk_sys(clk_sys), .reset(reset), .reg_req(reg_req), .reg_rdata_r(reg_rdata_r),
  .meas_strobe(meas_strobe), .meas_chan(meas_chan), .meas(meas),
  .beta_auto_strobe(beta_auto_strobe), .beta_auto_value(beta_auto_value),
  .auto_beta_on(auto_beta_on), .beta_setting(beta_setting),
  .diode_factor_value(diode_factor_value), .status_high_r(status_high_r),
  .status_low_r(status_low_r), .status_therm_r(status_therm_r),
  .overtemp_assert_r(overtemp_assert_r)
);

/* File: sim/tlm_host_model.sv */
// Purpose: register host standing in for the serial protocol engine
// Assumes: requests taken on the first rising edge they are seen
// Notes:   idle address and data are scrambled
`timescale 1ns/100ps
module tlm_host_model
  import tlm_pkg::*;
(
  input  wire logic       clk_sys,
  input  wire logic [7:0] reg_rdata_r,
  output tlm_reg_req_t    reg_req
);
  // no strobe at start
  initial reg_req = '{addr: 8'hA5, wr: 1'b0, rd: 1'b0, wdata: 8'h5A};
  // one write cycle
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_sys);
    reg_req = '{addr: a, wr: 1'b1, rd: 1'b0, wdata: d};
    @(negedge clk_sys);
    reg_req = '{addr: ~a, wr: 1'b0, rd: 1'b0, wdata: ~d};
  endtask : wr
  // one read cycle, answer taken once the registered data has landed
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk_sys);
    reg_req = '{addr: a, wr: 1'b0, rd: 1'b1, wdata: 8'h3C};
    @(negedge clk_sys);
    reg_req = '{addr: ~a, wr: 1'b0, rd: 1'b0, wdata: 8'hC3};
    d = reg_rdata_r;
  endtask : rd
endmodule : tlm_host_model

/* File: sim/testbench.sv */
// Purpose: directed register and measurement tests of the limit bank
// Assumes: all four external channels fitted
// Notes:   inputs change at falling edges only
`timescale 1ns/100ps
module testbench
  import tlm_pkg::*;
;
  logic            clk_sys = 1'b0;
  logic            reset = 1'b1;
  tlm_reg_req_t    reg_req;
  logic [7:0]      rdata;
  logic [3:0]      dflt = 4'h0;
  logic            meas_strobe = 1'b0;
  logic [2:0]      meas_chan = 3'h0;
  tlm_meas_t       meas = '0;
  logic [1:0]      b_stb = 2'h0;
  logic [1:0][3:0] b_val = '0;
  logic            st_high, st_low, st_therm, ot_pin, alert;
  int              num_errors = 0;
  int              check_count = 0;
  logic [2:0]      codes [4] = '{3'h0, 3'h1, 3'h3, 3'h7};
  logic [7:0]      ideal_a [4] = '{ADDR_IDEAL1, ADDR_IDEAL2, ADDR_IDEAL3, ADDR_IDEAL4};
  // 200 MHz clock
  always #2.5 clk_sys = ~clk_sys;
  tlm_host_model u_host (.clk_sys(clk_sys), .reg_rdata_r(rdata), .reg_req(reg_req));
  tlm_limit_bank #(.NUM_EXT(4)) u_dut (
    .clk_sys(clk_sys), .reset(reset), .reg_req(reg_req), .reg_rdata_r(rdata),
    .meas_strobe(meas_strobe), .meas_chan(meas_chan), .meas(meas),
    .diode_fault(dflt), .beta_auto_strobe(b_stb), .beta_auto_value(b_val),
    .auto_beta_on(), .beta_setting(), .diode_factor_value(),
    .status_high_r(st_high), .status_low_r(st_low), .status_therm_r(st_therm),
    .overtemp_assert_r(ot_pin), .alert_assert_r(alert)
  );
  // verdict and end of run
  task automatic final_report();
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : final_report
  // byte compare
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    check_count++;
    if (g !== e) begin
      num_errors++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  // read a register and compare
  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    u_host.rd(a, d);
    chk($sformatf("reg %h", a), e, d);
  endtask : rchk
  // falling-edge waits
  task automatic wt(input int n);
    repeat (n) @(negedge clk_sys);
  endtask : wt
  // one measurement strobe
  task automatic strobe(input logic [2:0] ch, input tlm_meas_t m);
    @(negedge clk_sys);
    {meas_chan, meas, meas_strobe} = {ch, m, 1'b1};
    @(negedge clk_sys);
    {meas, meas_strobe} = {~m, 1'b0};
  endtask : strobe
  // one detector result for ext1
  task automatic bstb(input logic [3:0] v);
    @(negedge clk_sys);
    {b_stb, b_val[0]} = {2'h1, v};
    @(negedge clk_sys);
    {b_stb, b_val[0]} = {2'h0, ~v};
  endtask : bstb
  // watchdog, run needs about 230 cycles
  initial begin
    #20000;
    num_errors++;
    final_report();
  end
  // main sequence
  initial begin
    repeat (4) @(posedge clk_sys);
    @(negedge clk_sys) reset = 1'b0;
    for (int i = 0; i < 4; i++) rchk(ideal_a[i], 8'h12);
    rchk(ADDR_BETA2, 8'h00);
    rchk(8'h50, 8'h00);
    u_host.wr(ADDR_IDEAL3, 8'hFF);
    rchk(ADDR_IDEAL3, 8'h3F);
    $display("test reset and ideality done");
    u_host.wr(ADDR_BETA1, 8'h05);
    rchk(ADDR_BETA1, 8'h05);
    u_host.wr(ADDR_BETA1, 8'h1A);
    rchk(ADDR_BETA1, 8'h15);
    bstb(4'h9);
    rchk(ADDR_BETA1, 8'h19);
    u_host.wr(ADDR_BETA1, 8'h13);
    rchk(ADDR_BETA1, 8'h19);
    u_host.wr(ADDR_BETA1, 8'h00);
    bstb(4'h3);
    rchk(ADDR_BETA1, 8'h09);
    $display("test beta done");
    for (int c = 0; c < 5; c++) begin
      strobe(3'(c), 4'hC);
      chk("st_high", 1, st_high);
      chk("st_low", 1, st_low);
      rchk(ADDR_HIGH, 8'(1 << c));
      chk("st_high", 0, st_high);
      rchk(ADDR_LOW, 8'(1 << c));
      chk("st_low", 0, st_low);
      rchk(ADDR_HIGH, 8'h00);
    end
    strobe(3'h5, 4'hF);
    wt(2);
    rchk(ADDR_HIGH, 8'h00);
    u_host.wr(ADDR_ALERT_MASK, 8'h1F);
    strobe(3'h1, 4'h8);
    wt(2);
    chk("alert", 0, alert);
    u_host.wr(ADDR_ALERT_MASK, 8'h00);
    wt(2);
    chk("alert", 1, alert);
    rchk(ADDR_HIGH, 8'h02);
    dflt = 4'h4;
    $display("test limit flags done");
    for (int i = 0; i < 4; i++) begin
      u_host.wr(ADDR_CONSEC, {1'b0, codes[i], 4'h0});
      for (int k = 0; k <= i; k++) begin
        wt(3);
        chk("ot_pin", 0, ot_pin);
        strobe(3'h2, 4'h2);
      end
      wt(2);
      chk("ot_pin", 1, ot_pin);
      rchk(ADDR_THERM, 8'h04);
      rchk(ADDR_THERM, 8'h04);
      chk("st_therm", 1, st_therm);
      chk("alert", 1, alert);
      strobe(3'h2, 4'h1);
      wt(2);
      chk("ot_pin", 0, ot_pin);
      rchk(ADDR_THERM, 8'h00);
    end
    u_host.wr(ADDR_ALERT_MASK, 8'h1F);
    u_host.wr(ADDR_CONSEC, 8'h00);
    strobe(3'h0, 4'h2);
    strobe(3'h3, 4'h2);
    wt(2);
    rchk(ADDR_THERM, 8'h09);
    chk("ot_pin", 1, ot_pin);
    chk("alert", 0, alert);
    strobe(3'h0, 4'h1);
    wt(2);
    chk("st_therm", 1, st_therm);
    strobe(3'h3, 4'h1);
    wt(2);
    chk("st_therm", 0, st_therm);
    $display("test overtemp done");
    final_report();
  end
endmodule : testbench
